// ---- verilog/dmm_defines.vh ----
`ifndef DMM_DEFINES_VH
`define DMM_DEFINES_VH
// Measurement functions
`define DMM_FN_DCV 4'h0
`define DMM_FN_ACV 4'h1
`define DMM_FN_DCI 4'h2
`define DMM_FN_ACI 4'h3
`define DMM_FN_RES 4'h4
`define DMM_FN_CONT 4'h5
`define DMM_FN_DIODE 4'h6
`define DMM_FN_FREQ 4'h7
`define DMM_FN_CAP 4'h8
`define DMM_FN_TEMP 4'h9
`define DMM_FN_ADP 4'ha
// Register offsets
`define DMM_REG_CTRL 4'h0
`define DMM_REG_RANGE 4'h1
`define DMM_REG_STAT 4'h2
`define DMM_REG_SEG0 4'h3
`define DMM_REG_SEG1 4'h4
`define DMM_REG_SEG2 4'h5
`define DMM_REG_SEG3 4'h6
`define DMM_REG_CFG 4'h7
// Control fields
`define DMM_CTRL_FN_LSB 0
`define DMM_CTRL_AUTO 4
`define DMM_CTRL_HOLD 5
`define DMM_CTRL_APO 6
`define DMM_CTRL_CELS 7
`define DMM_CTRL_NEG 8
`define DMM_CTRL_LBAT 9
`define DMM_CTRL_MAX 10
`define DMM_CTRL_MIN 11
`define DMM_CTRL_RS 12
`define DMM_CTRL_RST 32'h0000_0010
// Range fields: index low, then magnitude class
`define DMM_RNG_IDX_LSB 0
`define DMM_RNG_MAG_LSB 4
`define DMM_MAG_UNIT 3'h0
`define DMM_MAG_MILLI 3'h1
`define DMM_MAG_MICRO 3'h2
`define DMM_MAG_NANO 3'h3
`define DMM_MAG_KILO 3'h4
`define DMM_MAG_MEGA 3'h5
`define DMM_RANGE_RST 32'h0000_0000
// Timing, milliseconds, and clock rate
`define DMM_CLK_HZ 20000000
`define DMM_MS_CYC (`DMM_CLK_HZ / 1000)
`define DMM_T_EARLY_MS 100
`define DMM_T_DEINTEGRATE_PHASE_V_MS 600
`define DMM_T_DEINTEGRATE_PHASE_I_MS 300
`define DMM_T_EARLY_CD_MS 10
`define DMM_T_DEINTEGRATE_PHASE_CD_MS 60
`define DMM_T_FREQ_MS 1050
`define DMM_T_CAP_LO_MS 900
`define DMM_T_CAP_MID_MS 1800
`define DMM_T_CAP_HI_MS 4500
`define DMM_FAST_DIV 10
`define DMM_CAP_MID_RANGE 4'h5
`define DMM_CAP_HI_RANGE 4'h6
`endif

// ---- verilog/dmm_core.v ----
// The address-and-strobe port and the register offsets were left to the implementer.
`include "dmm_defines.vh"
module dmm_core #(
   parameter [31:0] MS_CYC = `DMM_MS_CYC
)(
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Register port
   input wire [3:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   // Range change from the auto-range logic
   input wire range_chg_i,
   // Converter phases
   output reg zero_integrator_phase_o,
   output reg auto_zero_phase_o,
   output reg integrate_phase_o,
   output reg deintegrate_phase_o,
   output reg cycle_done_o,
   // Panel segments, backplane one to four, segment line first at bit 0
   output reg [16:0] bp1_seg_o,
   output reg [16:0] bp2_seg_o,
   output reg [16:0] bp3_seg_o,
   output reg [16:0] bp4_seg_o
);
   localparam [3:0] ST_ZI = 4'b0001;
   localparam [3:0] ST_AZ = 4'b0010;
   localparam [3:0] ST_INT = 4'b0100;
   localparam [3:0] ST_DEINTEGRATE_PHASE = 4'b1000;

   reg [31:0] ctrl_r;
   reg [31:0] range_r;
   reg [31:0] digit_r;
   reg [3:0] state_r;
   reg [3:0] state_nxt;
   reg [31:0] ms_cnt_r;
   reg [31:0] ph_cnt_r;
   reg fast_r;
   reg chg_s1_r;
   reg chg_s2_r;
   reg [31:0] ph_len;
   wire [3:0] fn;
   wire [2:0] mag;
   wire [3:0] ridx;
   wire is_v;
   wire is_i;
   wire auto_on;
   wire fast_ok;
   wire ms_tick;
   wire ph_end;
   wire [31:0] tick_len;

   assign fn = ctrl_r[`DMM_CTRL_FN_LSB+3:`DMM_CTRL_FN_LSB];
   assign mag = range_r[`DMM_RNG_MAG_LSB+2:`DMM_RNG_MAG_LSB];
   assign ridx = range_r[`DMM_RNG_IDX_LSB+3:`DMM_RNG_IDX_LSB];
   assign is_v = fn_volt(fn);
   assign is_i = fn_amp(fn);
   assign auto_on = ctrl_r[`DMM_CTRL_AUTO];
   assign fast_ok = auto_on && (is_v || fn == `DMM_FN_RES || fn == `DMM_FN_FREQ);

   // Cycles per millisecond tick passed through as given, never below one
   function [31:0] ms2cyc;
      input [31:0] ms;
      begin
         ms2cyc = (ms == 32'h0) ? 32'h1 : ms;
      end
   endfunction

   // Voltage function decode
   function fn_volt;
      input [3:0] f;
      begin
         fn_volt = (f == `DMM_FN_DCV) || (f == `DMM_FN_ACV);
      end
   endfunction

   // Current function decode
   function fn_amp;
      input [3:0] f;
      begin
         fn_amp = (f == `DMM_FN_DCI) || (f == `DMM_FN_ACI);
      end
   endfunction

   // Register writes
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_r <= `DMM_CTRL_RST;
         range_r <= `DMM_RANGE_RST;
         digit_r <= 32'h0;
      end
      else if (wr_i)
      begin
         case (addr_i)
            `DMM_REG_CTRL: ctrl_r <= wdata_i;
            `DMM_REG_RANGE: range_r <= wdata_i;
            `DMM_REG_CFG: digit_r <= wdata_i;
            default: ;
         endcase
      end
   end

   // Range change input synchroniser
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         chg_s1_r <= 1'b0;
         chg_s2_r <= 1'b0;
      end
      else
      begin
         chg_s1_r <= range_chg_i;
         chg_s2_r <= chg_s1_r;
      end
   end

   // Phase lengths in milliseconds
   always @*
   begin
      ph_len = `DMM_T_EARLY_MS;
      if (fn == `DMM_FN_CONT || fn == `DMM_FN_DIODE)
         ph_len = (state_r == ST_DEINTEGRATE_PHASE) ? `DMM_T_DEINTEGRATE_PHASE_CD_MS : `DMM_T_EARLY_CD_MS;
      else if (is_i)
         ph_len = (state_r == ST_DEINTEGRATE_PHASE) ? `DMM_T_DEINTEGRATE_PHASE_I_MS : `DMM_T_EARLY_MS;
      else if (fn == `DMM_FN_FREQ)
         ph_len = (state_r == ST_DEINTEGRATE_PHASE) ? `DMM_T_FREQ_MS : 32'h1;
      else if (fn == `DMM_FN_CAP)
      begin
         if (state_r != ST_DEINTEGRATE_PHASE)
            ph_len = 32'h1;
         else if (ridx == `DMM_CAP_HI_RANGE)
            ph_len = `DMM_T_CAP_HI_MS;
         else if (ridx == `DMM_CAP_MID_RANGE)
            ph_len = `DMM_T_CAP_MID_MS;
         else
            ph_len = `DMM_T_CAP_LO_MS;
      end
      else
         ph_len = (state_r == ST_DEINTEGRATE_PHASE) ? `DMM_T_DEINTEGRATE_PHASE_V_MS : `DMM_T_EARLY_MS;
   end

   // Millisecond divider, tenfold faster while settling
   assign tick_len = fast_r ? ms2cyc(MS_CYC / `DMM_FAST_DIV) : ms2cyc(MS_CYC);
   assign ms_tick = (ms_cnt_r >= tick_len - 32'h1);
   assign ph_end = ms_tick && (ph_cnt_r >= ph_len - 32'h1);

   always @*
   begin
      case (state_r)
         ST_ZI: state_nxt = ST_AZ;
         ST_AZ: state_nxt = ST_INT;
         ST_INT: state_nxt = ST_DEINTEGRATE_PHASE;
         ST_DEINTEGRATE_PHASE: state_nxt = ST_ZI;
         default: state_nxt = ST_ZI;
      endcase
   end

   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r <= ST_ZI;
         ms_cnt_r <= 32'h0;
         ph_cnt_r <= 32'h0;
         fast_r <= 1'b0;
         cycle_done_o <= 1'b0;
      end
      else
      begin
         cycle_done_o <= 1'b0;
         ms_cnt_r <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
         if (ph_end)
         begin
            ph_cnt_r <= 32'h0;
            state_r <= state_nxt;
            if (state_r == ST_DEINTEGRATE_PHASE)
               cycle_done_o <= 1'b1;
         end
         else if (ms_tick)
            ph_cnt_r <= ph_cnt_r + 32'h1;
         // Fast mode set by a range change in auto range for volts, ohms or hertz, left at the end of the next de-integrate phase
         if (chg_s2_r && fast_ok)
            fast_r <= 1'b1;
         else if (!fast_ok || (ph_end && state_r == ST_DEINTEGRATE_PHASE))
            fast_r <= 1'b0;
      end
   end

   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         zero_integrator_phase_o <= 1'b0;
         auto_zero_phase_o <= 1'b0;
         integrate_phase_o <= 1'b0;
         deintegrate_phase_o <= 1'b0;
      end
      else
      begin
         zero_integrator_phase_o <= state_r[0];
         auto_zero_phase_o <= state_r[1];
         integrate_phase_o <= state_r[2];
         deintegrate_phase_o <= state_r[3];
      end
   end

   // Annunciators
   wire s_v = is_v || fn == `DMM_FN_DIODE || fn == `DMM_FN_ADP;
   wire s_a = is_i;
   wire s_ohm = fn == `DMM_FN_RES || fn == `DMM_FN_CONT;
   wire s_f = fn == `DMM_FN_CAP;
   wire s_cont = fn == `DMM_FN_CONT;
   wire s_diode = fn == `DMM_FN_DIODE;
   wire s_hz = fn == `DMM_FN_FREQ;
   wire s_dc = fn == `DMM_FN_DCV || fn == `DMM_FN_DCI;
   wire s_ac = fn == `DMM_FN_ACV || fn == `DMM_FN_ACI;
   wire auto_range_symbol = auto_on;
   wire manual_range_symbol = !auto_on;
   wire s_hold = ctrl_r[`DMM_CTRL_HOLD];
   wire capacitor_milli_prefix = s_f && mag == `DMM_MAG_MILLI;
   wire capacitor_micro_prefix = s_f && mag == `DMM_MAG_MICRO;
   wire s_nano = s_f && mag == `DMM_MAG_NANO;
   wire volt_amp_milli_prefix = (is_v || is_i) && mag == `DMM_MAG_MILLI;
   wire current_micro_prefix = is_i && mag == `DMM_MAG_MICRO;
   wire s_mega = fn == `DMM_FN_RES && mag == `DMM_MAG_MEGA;
   wire s_kilo = fn == `DMM_FN_RES && mag == `DMM_MAG_KILO;
   wire s_cel = fn == `DMM_FN_TEMP && ctrl_r[`DMM_CTRL_CELS];
   wire s_fah = fn == `DMM_FN_TEMP && !ctrl_r[`DMM_CTRL_CELS];
   wire auto_power_off_symbol = ctrl_r[`DMM_CTRL_APO];
   wire s_minus = (is_v || is_i) && ctrl_r[`DMM_CTRL_NEG];
   wire low_battery_symbol = ctrl_r[`DMM_CTRL_LBAT];
   wire s_max = ctrl_r[`DMM_CTRL_MAX];
   wire s_min = ctrl_r[`DMM_CTRL_MIN];
   wire s_rs = ctrl_r[`DMM_CTRL_RS];

   // Digit segments a..g and point, four digits from software
   wire [7:0] d4 = digit_r[31:24];
   wire [7:0] d3 = digit_r[23:16];
   wire [7:0] d2 = digit_r[15:8];
   wire [7:0] d1 = digit_r[7:0];

   // Panel map, segment line first is bit 0
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bp1_seg_o <= 17'h0;
         bp2_seg_o <= 17'h0;
         bp3_seg_o <= 17'h0;
         bp4_seg_o <= 17'h0;
      end
      else
      begin
         bp1_seg_o <= {
            s_cel,
            s_nano,
            current_micro_prefix,
            volt_amp_milli_prefix,
            s_min,
            s_a,
            s_v,
            s_diode,
            s_minus,
            d2[0],
            s_hold,
            d3[1],
            d3[0],
            manual_range_symbol,
            auto_range_symbol,
            s_dc,
            low_battery_symbol};
         bp2_seg_o <= {
            s_fah,
            capacitor_micro_prefix,
            2'b00,
            s_max,
            s_mega,
            d1[1],
            d1[0],
            d1[5],
            d2[1],
            d2[5],
            d3[6],
            d3[5],
            d4[1],
            d4[0],
            d4[5],
            s_ac};
         bp3_seg_o <= {
            1'b0,
            capacitor_milli_prefix,
            2'b00,
            1'b0,
            s_hz,
            d1[2],
            d1[6],
            d1[4],
            d2[6],
            d2[4],
            d3[2],
            d3[4],
            d4[2],
            d4[6],
            1'b0,
            auto_power_off_symbol};
         bp4_seg_o <= {
            1'b0,
            s_f,
            2'b00,
            1'b0,
            s_ohm,
            s_kilo,
            d1[3],
            d1[7],
            d2[2],
            d2[3],
            d2[7],
            d3[3],
            d3[7],
            d4[3],
            d4[4],
            s_rs};
      end
   end

   // Read port
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_o <= 32'h0;
      else if (rd_i)
      begin
         case (addr_i)
            `DMM_REG_CTRL: rdata_o <= ctrl_r;
            `DMM_REG_RANGE: rdata_o <= range_r;
            `DMM_REG_STAT: rdata_o <= {26'h0, fast_r, s_cont, state_r};
            `DMM_REG_SEG0: rdata_o <= {15'h0, bp1_seg_o};
            `DMM_REG_SEG1: rdata_o <= {15'h0, bp2_seg_o};
            `DMM_REG_SEG2: rdata_o <= {15'h0, bp3_seg_o};
            `DMM_REG_SEG3: rdata_o <= {15'h0, bp4_seg_o};
            `DMM_REG_CFG: rdata_o <= digit_r;
            default: rdata_o <= 32'h0;
         endcase
      end
      else
         rdata_o <= 32'h0;
   end
endmodule // dmm_core

// ---- verif/dmm_lcd_panel.sv ----
module dmm_lcd_panel (
   // Backplane segment lines
   input wire [16:0] bp1_i,
   input wire [16:0] bp2_i,
   input wire [16:0] bp3_i,
   input wire [16:0] bp4_i,
   // Decoded symbols
   output logic [21:0] sym_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Symbol lit where its backplane and segment line cross
   assign sym_o = {bp1_i[10], bp1_i[11], bp4_i[11], bp4_i[15], bp1_i[9], bp3_i[11],
      bp1_i[1], bp2_i[0], bp1_i[2], bp1_i[3], bp1_i[6], bp3_i[15], bp2_i[15], bp1_i[15],
      bp1_i[13], bp1_i[14], bp2_i[11], bp4_i[10], bp1_i[16], bp2_i[16], bp3_i[0],
      bp1_i[8]};
endmodule // dmm_lcd_panel

// ---- verif/dmm_core_chk.sv ----
module dmm_core_chk (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Register port
   input wire rd_i,
   input wire [31:0] rdata_o,
   // Converter phases
   input wire zero_integrator_phase_o,
   input wire auto_zero_phase_o,
   input wire integrate_phase_o,
   input wire deintegrate_phase_o,
   input wire cycle_done_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Phase ends
   sequence s_zi_end; $fell(zero_integrator_phase_o); endsequence
   sequence s_az_end; $fell(auto_zero_phase_o); endsequence
   sequence s_int_end; $fell(integrate_phase_o); endsequence
   sequence s_deintegrate_phase_end; $fell(deintegrate_phase_o); endsequence
   phase_one_hot_a: assert property (!$past(rst_i) |-> $onehot({zero_integrator_phase_o,
      auto_zero_phase_o, integrate_phase_o, deintegrate_phase_o}))
      else $error("phase outputs not one-hot");
   zi_to_az_a: assert property (s_zi_end |-> auto_zero_phase_o)
      else $error("auto-zero does not follow zero-integrator");
   az_to_int_a: assert property (s_az_end |-> integrate_phase_o)
      else $error("integrate does not follow auto-zero");
   int_to_deintegrate_phase_a: assert property (s_int_end |-> deintegrate_phase_o)
      else $error("de-integrate does not follow integrate");
   deintegrate_phase_to_zi_a: assert property (s_deintegrate_phase_end |-> zero_integrator_phase_o)
      else $error("zero-integrator does not follow de-integrate");
   done_at_deintegrate_phase_a: assert property (cycle_done_o |-> deintegrate_phase_o ||
      $past(deintegrate_phase_o)) else $error("cycle done away from de-integrate");
   done_pulse_a: assert property (cycle_done_o |=> !cycle_done_o)
      else $error("cycle done longer than one cycle");
   zi_min_len_a: assert property ($rose(zero_integrator_phase_o) |=>
      zero_integrator_phase_o) else $error("zero-integrator phase too short");
   rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside read cycle");
endmodule // dmm_core_chk
bind dmm_core dmm_core_chk u_dmm_core_chk (.clk_i(clk_i), .rst_i(rst_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .zero_integrator_phase_o(zero_integrator_phase_o),
   .auto_zero_phase_o(auto_zero_phase_o), .integrate_phase_o(integrate_phase_o),
   .deintegrate_phase_o(deintegrate_phase_o), .cycle_done_o(cycle_done_o));

// ---- verif/dmm_annunciator_and_phase_timing_bench.sv ----
`include "dmm_defines.vh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module dmm_annunciator_and_phase_timing_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MS = 20;
   logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, range_chg_i = 0;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0, d, c, r;
   wire [31:0] rdata_o;
   wire [16:0] bp1, bp2, bp3, bp4;
   wire [3:0] ph;
   wire done;
   wire [21:0] sym;
   logic [21:0] e;
   int fails = 0, cmp_count = 0, cyc = 0;
   always #25 clk_i = ~clk_i;
   dmm_core #(.MS_CYC(MS)) u_dmm_core (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .range_chg_i(range_chg_i), .zero_integrator_phase_o(ph[0]),
      .auto_zero_phase_o(ph[1]), .integrate_phase_o(ph[2]), .deintegrate_phase_o(ph[3]),
      .cycle_done_o(done), .bp1_seg_o(bp1), .bp2_seg_o(bp2), .bp3_seg_o(bp3),
      .bp4_seg_o(bp4));
   dmm_lcd_panel u_dmm_lcd_panel (.bp1_i(bp1), .bp2_i(bp2), .bp3_i(bp3), .bp4_i(bp4),
      .sym_o(sym));
   task results;
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 95000)
      begin
         fails++;
         results();
      end
   end
   task tick;
      @(posedge clk_i);
      #1;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask
   task sync;
      while (!ph[3]) tick();
      while (ph[3]) tick();
   endtask
   task plen(input int i, input int x);
      int n;
      n = 0;
      while (!ph[i]) tick();
      while (ph[i])
      begin
         n++;
         tick();
      end
      `CHK("phase_len", x, n)
   endtask
   function automatic logic [21:0] esym(input logic [31:0] c, input logic [31:0] r);
      logic [3:0] f;
      logic [2:0] m;
      logic vi;
      f = c[3:0];
      m = r[6:4];
      vi = f < 4'h4;
      esym = {f == 0 || f == 1 || f == 6 || f == 10, f == 2 || f == 3, f == 4 || f == 5,
         f == 8, f == 6, f == 7, f == 0 || f == 2, f == 1 || f == 3, c[4], !c[4], c[5],
         f == 8 && m == 1, f == 8 && m == 2, f == 8 && m == 3, vi && m == 1,
         (f == 2 || f == 3) && m == 2, f == 4 && m == 5, f == 4 && m == 4,
         f == 9 && c[7], f == 9 && !c[7], c[6], vi && c[8]};
   endfunction
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(4'h0, d);
      `CHK("ctrl_reset", 32'h0000_0010, d)
      rd(4'h9, d);
      `CHK("unmapped", 32'h0, d)
      sync();
      for (int i = 0; i < 4; i++) plen(i, (i == 3 ? 600 : 100) * MS);
      wr(4'h0, {28'h0, `DMM_FN_DCI});
      plen(3, 300 * MS);
      wr(4'h0, {28'h0, `DMM_FN_CONT});
      sync();
      for (int i = 0; i < 4; i++) plen(i, (i == 3 ? 60 : 10) * MS);
      for (int i = 0; i < 66; i++)
      begin
         c = {23'h0, i[4:0], 4'(i / 6)};
         r = {25'h0, 3'(i % 6), 4'h0};
         wr(4'h0, c);
         wr(4'h1, r);
         repeat (3) tick();
         e = esym(c, r);
         `CHK("fn_sym", e[21:14], sym[21:14])
         `CHK("flag_sym", e[13:0], sym[13:0])
         `CHK("flag_sym2", e[1:0], sym[1:0])
         rd(4'h2, d);
         `CHK("cont_flag", c[3:0] == `DMM_FN_CONT, d[4])
      end
      wr(4'h0, 32'h0000_1e10);
      wr(4'h1, 32'h0);
      wr(4'h7, 32'hffff_ffff);
      repeat (2) tick();
      rd(4'h7, d);
      `CHK("digits", 32'hffff_ffff, d)
      rd(4'h3, d);
      `CHK("seg_bp1", 32'h0000_14b7, d)
      rd(4'h4, d);
      `CHK("seg_bp2", 32'h0000_17fe, d)
      rd(4'h5, d);
      `CHK("seg_bp3", 32'h0000_07fc, d)
      rd(4'h6, d);
      `CHK("seg_bp4", 32'h0000_03ff, d)
      wr(4'h0, 32'h0000_0010);
      sync();
      @(posedge clk_i);
      range_chg_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      range_chg_i <= 1'b0;
      plen(1, 100 * MS / 10);
      plen(2, 100 * MS / 10);
      plen(3, 600 * MS / 10);
      plen(0, 100 * MS);
      wr(4'h0, 32'h0000_0017);
      @(posedge clk_i);
      range_chg_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      range_chg_i <= 1'b0;
      plen(3, 1050 * MS / 10);
      results();
   end
endmodule // dmm_annunciator_and_phase_timing_bench
